/* logic/sspr_defines.svh */
/*
 * Named constants of the serial register-access link: commands, status and
 * error codes, area bases, link timing and the controller's register map.
 * Assumes it is included by bare name from the design files.
 */
`ifndef SSPR_DEFINES_SVH
`define SSPR_DEFINES_SVH

// -----------------------------------------------------------------------
// Block layout and codes
// -----------------------------------------------------------------------
`define SSPR_BLK_LEN 3'd5
`define SSPR_BLK_EDGES 7'd80
`define SSPR_CMD_NOP 8'h00
`define SSPR_CMD_WR_LOW 8'h01
`define SSPR_CMD_WR_HIGH 8'h02
`define SSPR_ST_NONE 8'h00
`define SSPR_ST_OK 8'h01
`define SSPR_ST_FAIL 8'h02
`define SSPR_ERR_NONE 16'h0000
`define SSPR_ERR_CMD 16'h0001
`define SSPR_ERR_PROT 16'h0002
`define SSPR_ERR_SHORT 16'h0003
`define SSPR_CFG_BASE 16'h0000
`define SSPR_SSIN_BASE 16'h1001

// -----------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------
`define SSPR_SCLK_MAX_MHZ 20
`define SSPR_CLK_MHZ 50
`define SSPR_HS_MAX_MS 10
`define SSPR_HS_MAX_CYC (`SSPR_HS_MAX_MS * 1000 * `SSPR_CLK_MHZ)
`define SSPR_HALF_DIV_MIN ((`SSPR_CLK_MHZ + 2 * `SSPR_SCLK_MAX_MHZ - 1) / (2 * `SSPR_SCLK_MAX_MHZ))

// -----------------------------------------------------------------------
// Controller register map and fields
// -----------------------------------------------------------------------
`define SSPR_OFF_BLK0 8'h00
`define SSPR_OFF_BLK1 8'h04
`define SSPR_OFF_CTRL 8'h08
`define SSPR_OFF_REPLY0 8'h0c
`define SSPR_OFF_REPLY1 8'h10
`define SSPR_OFF_STAT 8'h14
`define SSPR_OFF_MASK 8'h18
`define SSPR_CTRL_START 0
`define SSPR_CTRL_CPOL 1
`define SSPR_CTRL_CPHA 2
`define SSPR_CTRL_BUSY 3
`define SSPR_IRQ_DONE 0
`define SSPR_IRQ_REFUSED 1
`define SSPR_IRQ_TIMEOUT 2
`define SSPR_IRQ_W 3
`define SSPR_RESP_OKAY 2'b00
`define SSPR_RESP_SLVERR 2'b10

`endif

/* logic/sspr_pkg.sv */
/*
 * Types shared by both ends of the serial register-access link.
 * Assumes nothing of its surroundings.
 */
package sspr_pkg;
    typedef logic [7:0] sspr_byte_t;
    typedef logic [15:0] sspr_word_t;
    typedef enum logic [1:0] {
        DV_IDLE = 2'b00,
        DV_XFER = 2'b01,
        DV_EXEC = 2'b10
    } sspr_dev_state_t;
    typedef enum logic [1:0] {
        MS_IDLE = 2'b00,
        MS_WAITRDY = 2'b01,
        MS_SHIFT = 2'b10,
        MS_WAITEND = 2'b11
    } sspr_mst_state_t;
endpackage : sspr_pkg

/* logic/sspr_link_if.sv */
/*
 * The five-wire link between the serial master and the register device.
 * Assumes the bench instantiates it once and binds both ends to it.
 */
`timescale 1ns/10ps
interface sspr_link_if;
    logic sclk;
    logic csel;
    logic mosi;
    logic miso;
    logic rdy;
    modport dev (input sclk, input csel, input mosi, output miso, output rdy);
    modport host (output sclk, output csel, output mosi, input miso, input rdy);
endinterface : sspr_link_if

/* logic/sspr_device.sv */
/*
 * Register device end of the serial link: receives five-byte blocks,
 * performs masked byte writes into its register memory, answers each
 * block with the status of the previous one.
 * Assumes a master that keeps the handshake and runs the serial clock
 * well below mclk; all link inputs are treated as asynchronous.
 */
// The implementer's own choices: the address map and register access over AXI4-Lite.
//
// How it works
// - Port works only in the selected slave mode.
// - Clock polarity and phase come from configuration.
// - Bytes go MSB first, back to back.
// - Master clock stays at or below 20 MHz.
// - Master waits for handshake before next block.
// - Ready low means status ready, next cycle allowed.
// - Master starts a cycle by raising select.
// - Ready rises soon after select rises.
// - Master drops select after the last bit.
// - Ready falls once status is loaded.
// - Each access opens with a five-byte block.
// - Writes only reach enabled register areas.
// - Input-area writes restart its validity timer.
// - Byte write: command, address, data, mask.
// - Only masked bits take the data byte.
// - Each block returns the previous access status.
// - Reply holds status, error code, two spare bytes.
`timescale 1ns/10ps
`include "sspr_defines.svh"
module sspr_device #(
    parameter int AREA_BITS = 4
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Serial link
    sspr_link_if.dev lnk,
    // Port configuration, held persistently by the application
    input wire logic cfgModeSpi,
    input wire logic cfgCpol,
    input wire logic cfgCpha,
    // Application view of the register memory
    input wire logic [AREA_BITS:0] usrAddr,
    output sspr_pkg::sspr_word_t usrData,
    output logic ssInRestart
);
    import sspr_pkg::*;

    localparam int MEM_WORDS = 2 << AREA_BITS;
    localparam logic [15:0] AREA_WORDS = 16'(1 << AREA_BITS);

    logic sclkM, sclkS, sclkD, csM, csS, mosiM, mosiS;
    sspr_dev_state_t state;
    logic rdyReg, misoReg;
    sspr_byte_t stCode, txSh;
    sspr_word_t stErr;
    logic [6:0] rxSh;
    logic [2:0] rxBit, rxCnt, txBit, txIdx;
    sspr_byte_t blk [0:4];
    sspr_word_t mem [0:MEM_WORDS-1];

    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sclkM <= 1'b0;
            sclkS <= 1'b0;
            sclkD <= 1'b0;
            csM <= 1'b0;
            csS <= 1'b0;
            mosiM <= 1'b0;
            mosiS <= 1'b0;
        end
        else
        begin
            sclkM <= lnk.sclk;
            sclkS <= sclkM;
            sclkD <= sclkS;
            csM <= lnk.csel;
            csS <= csM;
            mosiM <= lnk.mosi;
            mosiS <= mosiM;
        end
    end

    // ---------------------------------------------------------------
    // Edge decode and reply bytes
    // ---------------------------------------------------------------
    wire sclkRise = sclkS & ~sclkD;
    wire sclkFall = ~sclkS & sclkD;
    wire leadEdge = cfgCpol ? sclkFall : sclkRise;
    wire trailEdge = cfgCpol ? sclkRise : sclkFall;
    wire inXfer = state == DV_XFER;
    wire sampleEdge = inXfer & (cfgCpha ? trailEdge : leadEdge);
    wire shiftEdge = inXfer & (cfgCpha ? leadEdge : trailEdge);
    wire startNow = (state == DV_IDLE) & csS & cfgModeSpi;
    wire sspr_byte_t txByte = (txIdx == 3'd0) ? stCode :
                              (txIdx == 3'd1) ? stErr[15:8] :
                              (txIdx == 3'd2) ? stErr[7:0] : 8'h00;

    // ---------------------------------------------------------------
    // Command decode
    // ---------------------------------------------------------------
    // block fields
    wire sspr_word_t regAddr = {blk[1], blk[2]};
    wire sspr_word_t cfgOff = regAddr - `SSPR_CFG_BASE;
    wire sspr_word_t ssinOff = regAddr - `SSPR_SSIN_BASE;
    wire inCfg = cfgOff < AREA_WORDS;
    wire inSsin = ssinOff < AREA_WORDS;
    wire [AREA_BITS:0] memIdx = inSsin ? {1'b1, ssinOff[AREA_BITS-1:0]}
                                       : {1'b0, cfgOff[AREA_BITS-1:0]};
    wire isHigh = blk[0] == `SSPR_CMD_WR_HIGH;
    wire isWrite = isHigh | (blk[0] == `SSPR_CMD_WR_LOW);
    wire isNop = blk[0] == `SSPR_CMD_NOP;
    wire blkShort = rxCnt != `SSPR_BLK_LEN;
    wire writeOk = ~blkShort & isWrite & (inCfg | inSsin);
    wire sspr_word_t oldWord = mem[memIdx];
    wire sspr_byte_t oldByte = isHigh ? oldWord[15:8] : oldWord[7:0];
    wire sspr_byte_t newByte = (oldByte & ~blk[4]) | (blk[3] & blk[4]);
    wire sspr_word_t newWord = isHigh ? {newByte, oldWord[7:0]}
                                      : {oldWord[15:8], newByte};
    wire sspr_byte_t stNext = blkShort ? `SSPR_ST_FAIL :
                              isNop ? `SSPR_ST_NONE :
                              writeOk ? `SSPR_ST_OK : `SSPR_ST_FAIL;
    wire sspr_word_t errNext = blkShort ? `SSPR_ERR_SHORT :
                               (isNop | writeOk) ? `SSPR_ERR_NONE :
                               isWrite ? `SSPR_ERR_PROT : `SSPR_ERR_CMD;

    // ---------------------------------------------------------------
    // Handshake and status
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state <= DV_IDLE;
            rdyReg <= 1'b0;
            stCode <= `SSPR_ST_NONE;
            stErr <= `SSPR_ERR_NONE;
        end
        else
        begin
            case (state)
                DV_IDLE:
                    if (startNow)
                    begin
                        state <= DV_XFER;
                        rdyReg <= 1'b1;
                    end
                DV_XFER:
                    if (!csS)
                        state <= DV_EXEC;
                DV_EXEC:
                begin
                    stCode <= stNext;
                    stErr <= errNext;
                    rdyReg <= 1'b0;
                    state <= DV_IDLE;
                end
                default:
                    state <= DV_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Receive shifter
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rxSh <= 7'h00;
            rxBit <= 3'h0;
            rxCnt <= 3'h0;
            for (int i = 0; i < 5; i++)
                blk[i] <= 8'h00;
        end
        else if (state == DV_IDLE)
        begin
            rxBit <= 3'h0;
            rxCnt <= 3'h0;
        end
        else if (sampleEdge)
        begin
            rxSh <= {rxSh[5:0], mosiS};
            rxBit <= rxBit + 3'h1;
            if (rxBit == 3'h7 && !(rxCnt == `SSPR_BLK_LEN))
            begin
                blk[rxCnt] <= {rxSh, mosiS};
                rxCnt <= rxCnt + 3'h1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Transmit shifter
    // ---------------------------------------------------------------
    // With phase 0 the first bit must stand before the first edge, so it
    // is preloaded as the block is accepted; the next load is then one
    // bit early, which the bit counter accounts for.
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            misoReg <= 1'b0;
            txSh <= 8'h00;
            txBit <= 3'h0;
            txIdx <= 3'h0;
        end
        else if (startNow)
        begin
            misoReg <= ~cfgCpha & stCode[7];
            txSh <= {stCode[6:0], 1'b0};
            txBit <= {2'b00, ~cfgCpha};
            txIdx <= {2'b00, ~cfgCpha};
        end
        else if (state == DV_IDLE)
        begin
            misoReg <= 1'b0;
            txIdx <= 3'h0;
        end
        else if (shiftEdge)
        begin
            misoReg <= (txBit == 3'h0) ? txByte[7] : txSh[7];
            txSh <= (txBit == 3'h0) ? {txByte[6:0], 1'b0} : {txSh[6:0], 1'b0};
            txBit <= txBit + 3'h1;
            if (txBit == 3'h0 && txIdx != 3'h7)
                txIdx <= txIdx + 3'h1;
        end
    end

    // ---------------------------------------------------------------
    // Register memory
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < MEM_WORDS; i++)
                mem[i] <= 16'h0000;
            ssInRestart <= 1'b0;
            usrData <= 16'h0000;
        end
        else
        begin
            if (state == DV_EXEC && writeOk)
                mem[memIdx] <= newWord;
            ssInRestart <= (state == DV_EXEC) & writeOk & inSsin;
            usrData <= mem[usrAddr];
        end
    end

    assign lnk.miso = misoReg;
    assign lnk.rdy = rdyReg;
endmodule : sspr_device

/* logic/sspr_master.sv */
/*
 * Serial master end of the register-access link, run by software over
 * AXI4-Lite: one block per start, handshake with the device, reply kept.
 * Assumes a single AXI4-Lite master and a device on the link interface.
 */
`timescale 1ns/10ps
`include "sspr_defines.svh"
module sspr_master #(
    parameter int HALF_DIV = 8,
    parameter int HS_TIMEOUT_CYC = `SSPR_HS_MAX_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // AXI4-Lite write
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Interrupt
    output logic irq,
    // Serial link
    sspr_link_if.host lnk
);
    import sspr_pkg::*;

    sspr_mst_state_t state;
    logic rdyM, rdyS, misoM, misoS, csReg, sclkReg, mosiReg, cpolReg, cphaReg;
    logic [39:0] txSh, rxSh, reply;
    logic [31:0] blk0, blk1, wDat;
    logic [7:0] awA;
    logic [3:0] wStb;
    logic [`SSPR_IRQ_W-1:0] irqStat, irqMask;
    logic [6:0] edgeCnt;
    logic [15:0] divCnt;
    logic [31:0] hsCnt;

    // ---------------------------------------------------------------
    // Register decode
    // ---------------------------------------------------------------
    wire doWr = ~awready & ~wready & ~bvalid;
    wire [31:0] wMask = {{8{wStb[3]}}, {8{wStb[2]}}, {8{wStb[1]}}, {8{wStb[0]}}};
    wire wB0 = doWr & (awA == `SSPR_OFF_BLK0);
    wire wB1 = doWr & (awA == `SSPR_OFF_BLK1);
    wire wCt = doWr & (awA == `SSPR_OFF_CTRL) & wStb[0];
    wire wMk = doWr & (awA == `SSPR_OFF_MASK) & wStb[0];
    wire wHit = wB0 | wB1 | wMk | (doWr & (awA == `SSPR_OFF_CTRL));
    wire idle = state == MS_IDLE;
    wire startReq = wCt & wDat[`SSPR_CTRL_START];
    wire arTake = arvalid & arready;
    wire [31:0] ctrlView = (32'(~idle) << `SSPR_CTRL_BUSY)
        | (32'(cphaReg) << `SSPR_CTRL_CPHA) | (32'(cpolReg) << `SSPR_CTRL_CPOL);
    wire rHit = araddr == `SSPR_OFF_BLK0 || araddr == `SSPR_OFF_BLK1
        || araddr == `SSPR_OFF_CTRL || araddr == `SSPR_OFF_REPLY0
        || araddr == `SSPR_OFF_REPLY1 || araddr == `SSPR_OFF_STAT
        || araddr == `SSPR_OFF_MASK;
    wire [31:0] rdMux = (araddr == `SSPR_OFF_BLK0) ? blk0 :
        (araddr == `SSPR_OFF_BLK1) ? blk1 :
        (araddr == `SSPR_OFF_CTRL) ? ctrlView :
        (araddr == `SSPR_OFF_REPLY0) ? reply[39:8] :
        (araddr == `SSPR_OFF_REPLY1) ? {24'h000000, reply[7:0]} :
        (araddr == `SSPR_OFF_STAT) ? 32'(irqStat) :
        (araddr == `SSPR_OFF_MASK) ? 32'(irqMask) : 32'h00000000;

    // ---------------------------------------------------------------
    // Link timing
    // ---------------------------------------------------------------
    wire tick = divCnt == 16'(HALF_DIV - 1);
    wire hsOut = hsCnt == 32'(HS_TIMEOUT_CYC - 1);
    wire edgeNow = (state == MS_SHIFT) & tick & (edgeCnt != `SSPR_BLK_EDGES);
    wire sampleNow = edgeNow & (edgeCnt[0] == cphaReg);
    wire endNow = (state == MS_WAITEND) & ~rdyS;
    // The counter also runs during a frame, so only the two waits may report a timeout.
    wire hsWait = (state == MS_WAITRDY) | (state == MS_WAITEND);
    wire [`SSPR_IRQ_W-1:0] evSet = (`SSPR_IRQ_W'(endNow) << `SSPR_IRQ_DONE)
        | (`SSPR_IRQ_W'(startReq & ~idle) << `SSPR_IRQ_REFUSED)
        | (`SSPR_IRQ_W'(hsOut & hsWait) << `SSPR_IRQ_TIMEOUT);

    // ---------------------------------------------------------------
    // AXI4-Lite slave and interrupt
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            {awready, wready, arready} <= 3'b111;
            {bvalid, rvalid} <= 2'b00;
            {bresp, rresp} <= 4'h0;
            {awA, wStb, wDat, rdata} <= '0;
            blk0 <= 32'h00000000;
            blk1 <= 32'h00000000;
            {cpolReg, cphaReg, irq} <= 3'b000;
            irqStat <= '0;
            irqMask <= '0;
        end
        else
        begin
            if (awvalid & awready)
                {awready, awA} <= {1'b0, awaddr};
            if (wvalid & wready)
                {wready, wDat, wStb} <= {1'b0, wdata, wstrb};
            if (doWr)
                {bvalid, bresp} <= {1'b1, wHit ? `SSPR_RESP_OKAY : `SSPR_RESP_SLVERR};
            if (bvalid & bready)
                {bvalid, awready, wready} <= 3'b011;
            if (wB0)
                blk0 <= {8'h00, (blk0[23:0] & ~wMask[23:0]) | (wDat[23:0] & wMask[23:0])};
            if (wB1)
                blk1 <= {16'h0000, (blk1[15:0] & ~wMask[15:0]) | (wDat[15:0] & wMask[15:0])};
            if (wCt)
                {cphaReg, cpolReg} <= {wDat[`SSPR_CTRL_CPHA], wDat[`SSPR_CTRL_CPOL]};
            if (wMk)
                irqMask <= wDat[`SSPR_IRQ_W-1:0];
            if (arTake)
                {arready, rvalid, rdata} <= {2'b01, rdMux};
            if (arTake)
                rresp <= rHit ? `SSPR_RESP_OKAY : `SSPR_RESP_SLVERR;
            if (rvalid & rready)
                {rvalid, arready} <= 2'b01;
            // An event in the clearing read's cycle survives it.
            irqStat <= (irqStat & ~{`SSPR_IRQ_W{arTake & (araddr == `SSPR_OFF_STAT)}}) | evSet;
            irq <= |(irqStat & irqMask);
        end
    end

    // ---------------------------------------------------------------
    // Block sequencer
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state <= MS_IDLE;
            {csReg, sclkReg, rdyM, rdyS, misoM, misoS} <= 6'h00;
            {divCnt, edgeCnt, hsCnt} <= '0;
        end
        else
        begin
            {rdyM, misoM} <= {lnk.rdy, lnk.miso};
            {rdyS, misoS} <= {rdyM, misoM};
            divCnt <= tick ? 16'h0000 : divCnt + 16'h0001;
            hsCnt <= hsCnt + 32'h1;
            case (state)
                MS_IDLE:
                begin
                    sclkReg <= cpolReg;
                    hsCnt <= 32'h0;
                    if (startReq)
                    begin
                        csReg <= 1'b1;
                        state <= MS_WAITRDY;
                    end
                end
                MS_WAITRDY:
                    if (rdyS)
                    begin
                        {divCnt, edgeCnt} <= {16'h0000, 7'h00};
                        state <= MS_SHIFT;
                    end
                    else if (hsOut)
                    begin
                        {csReg, hsCnt} <= {1'b0, 32'h0};
                        state <= MS_WAITEND;
                    end
                MS_SHIFT:
                    // select low after the last bit
                    if (tick & (edgeCnt == `SSPR_BLK_EDGES))
                    begin
                        {csReg, hsCnt} <= {1'b0, 32'h0};
                        state <= MS_WAITEND;
                    end
                    else if (edgeNow)
                    begin
                        sclkReg <= ~sclkReg;
                        edgeCnt <= edgeCnt + 7'h01;
                    end
                MS_WAITEND:
                    // wait for the device to finish
                    if (endNow | hsOut)
                        state <= MS_IDLE;
                default:
                    state <= MS_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Data shifters
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            {txSh, rxSh, reply, mosiReg} <= '0;
        else if (idle & startReq)
            // command, address high first, data, mask
            txSh <= {blk0[7:0], blk0[23:8], blk1[7:0], blk1[15:8]};
        else if (((state == MS_WAITRDY) & rdyS & ~cphaReg) | (edgeNow & ~sampleNow))
            {mosiReg, txSh} <= {txSh[39], txSh[38:0], 1'b0};
        else if (sampleNow)
            rxSh <= {rxSh[38:0], misoS};
        else if (endNow)
            reply <= rxSh;
    end

    assign lnk.csel = csReg;
    assign lnk.sclk = sclkReg;
    assign lnk.mosi = mosiReg;
endmodule : sspr_master

/* verif/sspr_link_monitor.sv */
/* Link checker: handshake, clock gating and block length on the wires.
   Assumes it sees the link signals and the mclk domain of both ends. */
`timescale 1ns/10ps
// ------------
// Link checker
// ------------
module sspr_link_monitor (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Link
    input wire logic sclk,
    input wire logic csel,
    input wire logic rdy
);
    logic [6:0] edgeCnt_reg;
    logic sclkQ_reg;
    // The count rests at zero outside frames, so it needs no reset.
    wire logic [6:0] edgeCnt_next = csel ? edgeCnt_reg + 7'(sclk ^ sclkQ_reg) : 7'h00;
    always_ff @(posedge mclk)
    begin
        edgeCnt_reg <= edgeCnt_next;
        sclkQ_reg <= sclk;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence s_open; csel ##[1:10] rdy; endsequence
    sequence s_close; !csel ##[1:10] !rdy; endsequence
    property p_open; $rose(csel) |-> s_open; endproperty
    property p_close; $fell(csel) |-> s_close; endproperty
    property p_cause; $rose(rdy) |-> csel; endproperty
    property p_hold; rdy && csel |=> rdy; endproperty
    property p_next; $rose(csel) |-> !$past(rdy); endproperty
    property p_gate; csel && !rdy |-> $stable(sclk); endproperty
    property p_half; csel && $changed(sclk) |=> $stable(sclk); endproperty
    property p_count; $fell(csel) |-> edgeCnt_reg == 7'h50; endproperty
    a_open: assert property (p_open) else $error("ready late");
    a_close: assert property (p_close) else $error("ready not dropped");
    a_cause: assert property (p_cause) else $error("ready without select");
    a_hold: assert property (p_hold) else $error("ready fell in frame");
    a_next: assert property (p_next) else $error("select while busy");
    a_gate: assert property (p_gate) else $error("clock before ready");
    a_half: assert property (p_half) else $error("clock too fast");
    a_count: assert property (p_count) else $error("wrong edge count");
endmodule : sspr_link_monitor

/* verif/spi_slave_register_access_tb.sv */
/* Bench: AXI4-Lite drives the master end, which runs blocks to the device end.
   Assumes the package, both ends, the link interface and its monitor. */
`timescale 1ns/10ps
// -----
// Bench
// -----
module spi_slave_register_access_tb;
    import sspr_pkg::*;
    logic mclk = 1'h0, sys_rst = 1'h1, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h1;
    logic arvalid = 1'h0, rready = 1'h1, cfgModeSpi = 1'h1, cfgCpol = 1'h0, cfgCpha = 1'h0;
    logic msk, awready, wready, bvalid, arready, rvalid, irq, ssInRestart;
    logic [1:0] bresp, rresp;
    logic [3:0] wstrb = 4'hf;
    logic [4:0] usrAddr = 5'h00;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, cmds [10] = '{8'h01, 8'h02, 8'h01, 8'h02,
        8'h01, 8'h01, 8'h04, 8'h02, 8'h00, 8'h00};
    logic [15:0] adrs [10] = '{16'h0003, 16'h0003, 16'h1001, 16'h1010, 16'h1011, 16'h0010,
        16'h0003, 16'h000f, 16'h0000, 16'h0000};
    logic [23:0] rep = 24'h000000;
    logic [31:0] wdata = 32'h0, rdata, rs = 32'he485, q [$];
    sspr_word_t usrData, mem [32] = '{default: 16'h0000};
    int err_total = 0, compares = 0, cyc = 0, nRst = 0, nExp = 0;
    sspr_link_if lnk ();
    sspr_master #(.HALF_DIV(8), .HS_TIMEOUT_CYC(64)) sspr_master_inst (.mclk(mclk),
        .sys_rst(sys_rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .irq(irq), .lnk(lnk));
    sspr_device sspr_device_inst (.mclk(mclk), .sys_rst(sys_rst), .lnk(lnk),
        .cfgModeSpi(cfgModeSpi), .cfgCpol(cfgCpol), .cfgCpha(cfgCpha),
        .usrAddr(usrAddr), .usrData(usrData), .ssInRestart(ssInRestart));
    sspr_link_monitor sspr_link_monitor_inst (.mclk(mclk), .sys_rst(sys_rst), .sclk(lnk.sclk),
        .csel(lnk.csel), .rdy(lnk.rdy));
    always #10 mclk = ~mclk;
    task chk(input string n, input logic [31:0] g, input logic [31:0] e);
        compares++;
        err_total += int'(g !== e);
        if (g !== e) $display("mismatch %s exp %h got %h", n, e, g);
    endtask : chk
    task summarize();
        if (err_total == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize
    function logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    // This end takes address and data together, so both are released at once.
    task wr(input logic [7:0] a, input logic [31:0] d);
        q.push_back({30'h0, a > 8'h18, 1'h0});
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid} <= 2'h3;
        @(posedge mclk iff (awready && wready));
        {awvalid, wvalid} <= 2'h0;
        @(posedge mclk iff bvalid);
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e);
        q.push_back(e);
        q.push_back({30'h0, a > 8'h18, 1'h0});
        araddr <= a;
        arvalid <= 1'h1;
        @(posedge mclk iff arready);
        arvalid <= 1'h0;
        @(posedge mclk iff rvalid);
    endtask : rd
    task blk(input logic [7:0] c, input logic [15:0] a);
        int i;
        rs = xs(rs);
        i = a < 16'h0010 ? a : a - 16'h0ff1;
        wr(8'h00, {8'h00, a, c});
        wr(8'h04, {16'h0000, rs[15:0]});
        wr(8'h08, {29'h0, cfgCpha, cfgCpol, 1'h0});
        wr(8'h08, {29'h0, cfgCpha, cfgCpol, 1'h1});
        // a start inside the frame is refused.
        if (c > 8'h02) wr(8'h08, {29'h0, cfgCpha, cfgCpol, 1'h1});
        @(negedge lnk.rdy);
        repeat (6) @(posedge mclk);
        chk("irq", irq, msk);
        rd(8'h14, {30'h0, c > 8'h02, 1'h1});
        rd(8'h0c, {rep, 8'h00});
        rd(8'h10, 32'h0);
        if (c == 8'h00) rep = 24'h0;
        else if (c > 8'h02) rep = 24'h020001;
        else if (a > 16'h000f && (a < 16'h1001 || a > 16'h1010)) rep = 24'h020002;
        else
        begin
            rep = 24'h010000;
            if (c == 8'h01) mem[i][7:0] = mem[i][7:0] & ~rs[15:8] | rs[7:0] & rs[15:8];
            else mem[i][15:8] = mem[i][15:8] & ~rs[15:8] | rs[7:0] & rs[15:8];
            nExp += int'(i > 15);
            usrAddr <= 5'(i);
            repeat (2) @(posedge mclk);
            chk("usrData", usrData, mem[i]);
        end
    endtask : blk
    always @(posedge mclk)
    begin
        cyc++;
        if (rvalid === 1'h1) chk("rdata", rdata, q.pop_front());
        if (rvalid === 1'h1) chk("rresp", {30'h0, rresp}, q.pop_front());
        if (bvalid === 1'h1) chk("bresp", {30'h0, bresp}, q.pop_front());
        nRst += int'(ssInRestart === 1'h1);
        if (cyc == 20000) err_total++;
        if (cyc == 20000) summarize();
    end
    initial
    begin
        repeat (6) @(posedge mclk);
        sys_rst <= 1'h0;
        @(posedge mclk);
        rd(8'h1c, 32'h0);
        wr(8'h1c, 32'h0);
        for (int k = 0; k < 10; k++)
        begin
            {cfgCpha, cfgCpol} <= 2'(k);
            msk = k > 3;
            if (k == 4) wr(8'h18, 32'h1);
            blk(cmds[k], adrs[k]);
        end
        repeat (3) @(posedge mclk);
        chk("irq", irq, 1'h0);
        chk("restart", nRst, nExp);
        summarize();
    end
endmodule : spi_slave_register_access_tb
